// ---- rtl/lcsc_regs.vh ----
// Register map, field positions, reset values and timing counts.
`ifndef LCSC_REGS_VH
`define LCSC_REGS_VH

// Byte addresses of the registers
`define LCSC_ADDR_CONFIG 8'h00
`define LCSC_ADDR_CONTROL 8'h04
`define LCSC_ADDR_CONTRAST 8'h08
`define LCSC_ADDR_STATUS 8'h0C

// Display-method register fields
`define LCSC_CFG_W 11
`define LCSC_CFG_DUTY_LSB 0
`define LCSC_CFG_DUTY_MSB 3
`define LCSC_CFG_BIAS_RATIO 4
`define LCSC_CFG_INVERSION 5
`define LCSC_CFG_SCAN_REV 6
`define LCSC_CFG_SEG_REV 7
`define LCSC_CFG_CONTRAST_RUN 8
`define LCSC_CFG_BIAS_RUN 9
`define LCSC_CFG_BOOSTER_RUN 10
`define LCSC_CFG_RST 11'h000

// Control register fields
`define LCSC_CTL_POWER_SAVE 0
`define LCSC_CTL_RST 1'b0

// Contrast register fields
`define LCSC_CONTRAST_W 6
`define LCSC_CONTRAST_RST 6'h00

// Status register fields
`define LCSC_STS_ROW_LSB 0
`define LCSC_STS_ROW_MSB 3
`define LCSC_STS_DISCHARGE 4
`define LCSC_STS_POLARITY 5
`define LCSC_STS_SCANNING 6
`define LCSC_STS_CLEARED 7
`define LCSC_STS_CFG_LSB 16

// Duty decoding
`define LCSC_DUTY_BASE 5'h08
`define LCSC_DUTY_FULL 5'h10
`define LCSC_NUM_COMMONS 16

// Bias ratios
`define LCSC_BIAS_QUARTER 3'h4
`define LCSC_BIAS_FIFTH 3'h5

// Row period and the cycles it takes at the core clock
`define LCSC_CLK_PERIOD_NS 10
`define LCSC_ROW_PERIOD_NS 10000
`define LCSC_ROW_CYCLES (`LCSC_ROW_PERIOD_NS / `LCSC_CLK_PERIOD_NS)

`endif

// ---- rtl/lcsc_row_timer.v ----
// Row timer: paces common rows and marks frame boundaries.
`timescale 1ns/1ns
`default_nettype none
`include "lcsc_regs.vh"

module lcsc_row_timer #(
    parameter ROW_CYCLES = `LCSC_ROW_CYCLES
) (
    input wire clk_in,
    input wire rstn_in,
    input wire run_in,
    input wire [4:0] rows_in,
    output reg [3:0] row_out,
    output reg row_tick_out,
    output reg frame_start_out
);

    localparam [15:0] LAST_CYCLE = ROW_CYCLES[15:0] - 16'h0001;

    reg [15:0] cycle_cnt;

    ////////////////////////////////////////////////////////////////////
    // Frame end: last cycle of the last row, so settings and polarity
    // switch on the same edge that restarts row 0
    always @* begin
        frame_start_out = run_in & (cycle_cnt == LAST_CYCLE)
            & ({1'b0, row_out} >= rows_in - 5'h01);
    end

    // Cycle and row counters; idle timer waits at row 0
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cycle_cnt <= 16'h0000;
            row_out <= 4'h0;
            row_tick_out <= 1'b0;
        end else if (!run_in) begin
            cycle_cnt <= 16'h0000;
            row_out <= 4'h0;
            row_tick_out <= 1'b0;
        end else if (cycle_cnt == LAST_CYCLE) begin
            cycle_cnt <= 16'h0000;
            row_tick_out <= 1'b1;
            // Wrap after the last scanned row of the frame
            if (frame_start_out)
                row_out <= 4'h0;
            else
                row_out <= row_out + 4'h1;
        end else begin
            cycle_cnt <= cycle_cnt + 16'h0001;
            row_tick_out <= 1'b0;
        end
    end

endmodule // lcsc_row_timer
`default_nettype wire

// ---- rtl/lcsc_scan_config.v ----
// Display-method configuration, discharge control and common scan.
//
// Behaviour
// (R1) Clear pin low forces bias circuits discharge
// (R2) Power saving with a run bit discharges both
// (R3) Discharge drives all bias levels to lowest
// (R4) Duty field plus eight; top bit gives 1/16
// (R5) Scan rows in direction, blank the rest
// (R6) Ratio bit selects 1/4 or 1/5 bias
// (R7) Inversion bit: line or frame inversion
// (R8) Running adjuster sets top level from contrast
// (R9) Contrast and bias circuits run independently
// (R10) Host sends display method first after clear
// (R11) Scan settings change only at frame boundary; code also reloads them while not scanning
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "lcsc_regs.vh"

module lcsc_scan_config #(
    parameter ROW_CYCLES = `LCSC_ROW_CYCLES
) (
    input wire clk_in,
    input wire rstn_in,
    input wire chip_clear_input_n_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output reg hreadyout_out,
    output reg hresp_out,
    output reg [31:0] hrdata_out,
    output reg [15:0] common_outputs_out,
    output reg [15:0] common_blank_out,
    output reg polarity_out,
    output reg bias_discharge_out,
    output reg [5:0] top_bias_level_out,
    output reg contrast_adjuster_active_out,
    output reg bias_generator_active_out,
    output reg booster_active_out,
    output reg [2:0] bias_divider_out,
    output reg bias_level3_open_out,
    output reg segment_map_reverse_out
);

    ////////////////////////////////////////////////////////////////////
    // Shared decoders

    // Number of scanned rows for a duty field
    function [4:0] lcsc_duty_rows;
        input [3:0] duty;
        begin
            if (duty[3])
                lcsc_duty_rows = `LCSC_DUTY_FULL;
            else
                lcsc_duty_rows = {1'b0, duty} + `LCSC_DUTY_BASE;
        end
    endfunction

    // Common index driven for a row in the given direction
    function [3:0] lcsc_com_index;
        input [3:0] row;
        input reverse;
        begin
            if (reverse)
                lcsc_com_index = 4'hF - row;
            else
                lcsc_com_index = row;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Clear pin synchroniser and filter

    reg clr_s1;
    reg clr_s2;
    reg clr_s3;
    reg clear_active;

    // Level counts once the last two stages agree
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clr_s1 <= 1'b0;
            clr_s2 <= 1'b0;
            clr_s3 <= 1'b0;
            clear_active <= 1'b1;
        end else begin
            clr_s1 <= chip_clear_input_n_in;
            clr_s2 <= clr_s1;
            clr_s3 <= clr_s2;
            if (clr_s2 == clr_s3)
                clear_active <= ~clr_s3;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: address phase capture

    wire addr_valid;
    reg wr_pend;
    reg [7:0] wr_addr;

    assign addr_valid = hsel_in & hready_in & htrans_in[1];

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_valid & hwrite_in;
            if (addr_valid & hwrite_in)
                wr_addr <= haddr_in[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Software registers

    reg [`LCSC_CFG_W-1:0] cfg_shadow;
    reg power_save;
    reg [`LCSC_CONTRAST_W-1:0] contrast_level;

    // Clear pin returns every setting to its reset value [R10]
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_shadow <= `LCSC_CFG_RST;
            power_save <= `LCSC_CTL_RST;
            contrast_level <= `LCSC_CONTRAST_RST;
        end else if (clear_active) begin
            cfg_shadow <= `LCSC_CFG_RST;
            power_save <= `LCSC_CTL_RST;
            contrast_level <= `LCSC_CONTRAST_RST;
        end else if (wr_pend) begin
            case (wr_addr)
                `LCSC_ADDR_CONFIG: begin
                    cfg_shadow <= hwdata_in[`LCSC_CFG_W-1:0];
                end
                `LCSC_ADDR_CONTROL: begin
                    power_save <= hwdata_in[`LCSC_CTL_POWER_SAVE];
                end
                `LCSC_ADDR_CONTRAST: begin
                    contrast_level <= hwdata_in[`LCSC_CONTRAST_W-1:0];
                end
                default: cfg_shadow <= cfg_shadow;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Run state, discharge and scan settings in force

    wire run_contrast;
    wire run_bias;
    wire run_booster;
    wire discharge;
    wire scan_run;
    wire frame_start;
    wire [3:0] row;
    reg [3:0] act_duty;
    reg act_reverse;
    reg act_inversion;
    reg frame_parity;
    wire [4:0] act_rows;

    // Each circuit follows its own run bit [R9]
    assign run_contrast = cfg_shadow[`LCSC_CFG_CONTRAST_RUN]; // [R9]
    assign run_bias = cfg_shadow[`LCSC_CFG_BIAS_RUN]; // [R9]
    assign run_booster = cfg_shadow[`LCSC_CFG_BOOSTER_RUN];

    // Forced discharge on clear or power saving with the contrast or bias run bit
    assign discharge = clear_active // [R1]
        | (power_save & (run_contrast | run_bias)); // [R2]
    assign scan_run = ~clear_active & ~power_save;
    assign act_rows = lcsc_duty_rows(act_duty); // [R4]

    // Scan settings latch while idle or at a frame start [R11]
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            act_duty <= 4'h0;
            act_reverse <= 1'b0;
            act_inversion <= 1'b0;
        end else if (!scan_run | frame_start) begin // [R11]
            act_duty <= cfg_shadow[`LCSC_CFG_DUTY_MSB:`LCSC_CFG_DUTY_LSB];
            act_reverse <= cfg_shadow[`LCSC_CFG_SCAN_REV];
            act_inversion <= cfg_shadow[`LCSC_CFG_INVERSION];
        end
    end

    // Frame polarity flips at each frame boundary
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in)
            frame_parity <= 1'b0;
        else if (!scan_run)
            frame_parity <= 1'b0;
        else if (frame_start)
            frame_parity <= ~frame_parity;
    end

    lcsc_row_timer #(
        .ROW_CYCLES(ROW_CYCLES)
    ) u_row_timer (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .run_in(scan_run),
        .rows_in(act_rows),
        .row_out(row),
        .row_tick_out(),
        .frame_start_out(frame_start)
    );

    ////////////////////////////////////////////////////////////////////
    // Common scan pattern

    wire [3:0] scan_index;
    wire [4:0] blank_floor;
    wire [15:0] next_common;
    wire [15:0] next_blank;

    assign scan_index = lcsc_com_index(row, act_reverse); // [R5]
    assign blank_floor = `LCSC_DUTY_FULL - act_rows;

    genvar gi;
    generate
        for (gi = 0; gi < `LCSC_NUM_COMMONS; gi = gi + 1) begin : g_com
            localparam [4:0] IDX = gi;
            // Scan pulse on the current row's common [R5]
            assign next_common[gi] = scan_run & (scan_index == IDX[3:0]);
            // Commons past the duty get display-off pulses [R5]
            assign next_blank[gi] = scan_run & (act_reverse ?
                (IDX < blank_floor) : (IDX >= act_rows));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Drive waveform polarity and bias outputs

    wire next_polarity;
    wire [5:0] next_top;
    wire [2:0] next_divider;

    // Line inversion adds row parity; frame inversion does not [R7]
    assign next_polarity = act_inversion ? frame_parity // [R7]
        : (frame_parity ^ row[0]); // [R7]

    // Top level from contrast only while the adjuster runs [R8]
    assign next_top = (discharge | ~run_contrast) ? 6'h00 // [R3]
        : contrast_level; // [R8]

    // Divider four or five; nothing driven in discharge [R6]
    assign next_divider = (discharge | ~run_bias) ? 3'h0 // [R3]
        : (cfg_shadow[`LCSC_CFG_BIAS_RATIO] ? `LCSC_BIAS_FIFTH
        : `LCSC_BIAS_QUARTER); // [R6]

    // Registered pin-side outputs
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            common_outputs_out <= 16'h0000;
            common_blank_out <= 16'h0000;
            polarity_out <= 1'b0;
            bias_discharge_out <= 1'b1;
            top_bias_level_out <= 6'h00;
            contrast_adjuster_active_out <= 1'b0;
            bias_generator_active_out <= 1'b0;
            booster_active_out <= 1'b0;
            bias_divider_out <= 3'h0;
            bias_level3_open_out <= 1'b1;
            segment_map_reverse_out <= 1'b0;
        end else begin
            common_outputs_out <= next_common;
            common_blank_out <= next_blank;
            polarity_out <= scan_run & next_polarity;
            bias_discharge_out <= discharge; // [R1] [R2] [R3]
            top_bias_level_out <= next_top;
            contrast_adjuster_active_out <= run_contrast & ~discharge;
            bias_generator_active_out <= run_bias & ~discharge;
            booster_active_out <= run_booster & ~clear_active
                & ~power_save;
            bias_divider_out <= next_divider;
            // Level 3 tap is left open under 1/4 bias [R6]
            bias_level3_open_out <= ~cfg_shadow[`LCSC_CFG_BIAS_RATIO];
            segment_map_reverse_out <= cfg_shadow[`LCSC_CFG_SEG_REV];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite read data and response

    reg [31:0] next_rdata;

    // Read mux; unmapped addresses read zero
    always @* begin
        next_rdata = 32'h00000000;
        case (haddr_in[7:0])
            `LCSC_ADDR_CONFIG: begin
                next_rdata[`LCSC_CFG_W-1:0] = cfg_shadow;
            end
            `LCSC_ADDR_CONTROL: begin
                next_rdata[`LCSC_CTL_POWER_SAVE] = power_save;
            end
            `LCSC_ADDR_CONTRAST: begin
                next_rdata[`LCSC_CONTRAST_W-1:0] = contrast_level;
            end
            `LCSC_ADDR_STATUS: begin
                next_rdata[`LCSC_STS_ROW_MSB:`LCSC_STS_ROW_LSB] = row;
                next_rdata[`LCSC_STS_DISCHARGE] = discharge;
                next_rdata[`LCSC_STS_POLARITY] = polarity_out;
                next_rdata[`LCSC_STS_SCANNING] = scan_run;
                next_rdata[`LCSC_STS_CLEARED] = clear_active;
                next_rdata[`LCSC_STS_CFG_LSB+3:`LCSC_STS_CFG_LSB] =
                    act_duty;
                next_rdata[`LCSC_STS_CFG_LSB+4] = act_reverse;
                next_rdata[`LCSC_STS_CFG_LSB+5] = act_inversion;
            end
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Zero-wait slave, always OKAY; read data lands in data phase
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            hrdata_out <= 32'h00000000;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            if (addr_valid & ~hwrite_in)
                hrdata_out <= next_rdata;
        end
    end

    // Transfer size and upper address bits are ignored
    wire unused_ok;
    assign unused_ok = &{1'b0, hsize_in, haddr_in[31:8]};

endmodule // lcsc_scan_config
`default_nettype wire

// ---- verif/lcsc_scan_config_props.sv ----
// Checker: port-level properties of the scan configuration block.
`timescale 1ns/1ns
`default_nettype none

module lcsc_scan_config_props #(
    parameter ROW_CYCLES = 1000
) (
    input wire clk_in,
    input wire rstn_in,
    input wire chip_clear_input_n_in,
    input wire hreadyout_out,
    input wire hresp_out,
    input wire [15:0] common_outputs_out,
    input wire [15:0] common_blank_out,
    input wire bias_discharge_out,
    input wire [5:0] top_bias_level_out,
    input wire contrast_adjuster_active_out,
    input wire bias_generator_active_out,
    input wire [2:0] bias_divider_out,
    input wire bias_level3_open_out
);
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_clear_discharge: assert property (
        !chip_clear_input_n_in [*8] |-> bias_discharge_out)
        else $error("no discharge while clear pad held low");
    a_discharge_levels: assert property (
        bias_discharge_out |-> top_bias_level_out == 6'h00
        && bias_divider_out == 3'h0 && !contrast_adjuster_active_out)
        else $error("bias levels not at lowest in discharge");
    a_discharge_stops: assert property (
        bias_discharge_out [*3] |-> common_outputs_out == 16'h0000)
        else $error("scan pulses during discharge");
    a_scan_onehot: assert property (
        $onehot0(common_outputs_out))
        else $error("more than one common pulsed");
    a_blank_apart: assert property (
        (common_outputs_out & common_blank_out) == 16'h0000)
        else $error("scan pulse on a blanked common");
    a_ratio_level3: assert property (
        bias_generator_active_out |-> bias_divider_out
        == (bias_level3_open_out ? 3'h4 : 3'h5))
        else $error("divider does not match bias ratio");
    a_top_idle: assert property (
        !contrast_adjuster_active_out |-> top_bias_level_out == 6'h00)
        else $error("top level set while adjuster stopped");
    a_bus_okay: assert property (
        hreadyout_out && !hresp_out)
        else $error("bus response not ready and okay");
endmodule // lcsc_scan_config_props

bind lcsc_scan_config lcsc_scan_config_props #(
    .ROW_CYCLES(ROW_CYCLES)
) i_lcsc_scan_config_props (
    .clk_in, .rstn_in, .chip_clear_input_n_in, .hreadyout_out,
    .hresp_out, .common_outputs_out, .common_blank_out,
    .bias_discharge_out, .top_bias_level_out,
    .contrast_adjuster_active_out, .bias_generator_active_out,
    .bias_divider_out, .bias_level3_open_out
);
`default_nettype wire

// ---- verif/lcsc_host_model.sv ----
// Host model: single-word bus master sending setting words.
`timescale 1ns/1ns
`default_nettype none

module lcsc_host_model (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    int timeouts = 0;

    // Idle bus at time zero
    initial begin
        hsel_out = 1'b1;
        haddr_out = 32'h00000000;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h00000000;
    end

    // Waits for ready at a rising edge, bounded
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (hready_in !== 1'b1 && k < 50);
        if (hready_in !== 1'b1)
            timeouts++;
    endtask

    // One transfer; read data taken at the data-phase edge
    task automatic xfer(input bit wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_in);
        haddr_out <= {24'h000000, a};
        hwrite_out <= wr;
        htrans_out <= 2'h2;
        wait_ready();
        htrans_out <= 2'h0;
        hwdata_out <= wd;
        wait_ready();
        rd = hrdata_in;
    endtask
endmodule // lcsc_host_model
`default_nettype wire

// ---- verif/lcsc_scan_config_tb_top.sv ----
// Testbench: register-driven checks of scan and bias control.
`timescale 1ns/1ns
`default_nettype none
`include "lcsc_regs.vh"

module lcsc_scan_config_tb_top;
    localparam int RC = 4;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic clear_n = 1'b1;
    wire hsel, hwrite, hreadyout, hresp, polarity, discharge;
    wire [1:0] htrans;
    wire [2:0] hsize, divider;
    wire [31:0] haddr, hwdata, hrdata;
    wire [15:0] commons, blank;
    wire [5:0] top;
    wire ca_act, bg_act, lvl3, boost, seg_rev;
    int bad_count = 0;
    int n_compared = 0;

    lcsc_host_model i_lcsc_host_model (.clk_in(clk_in),
        .hready_in(hreadyout), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
        .hsize_out(hsize), .hwdata_out(hwdata));
    lcsc_scan_config #(.ROW_CYCLES(RC)) i_lcsc_scan_config (
        .clk_in(clk_in), .rstn_in(rstn_in),
        .chip_clear_input_n_in(clear_n), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hreadyout_out(hreadyout), .hresp_out(hresp),
        .hrdata_out(hrdata), .common_outputs_out(commons),
        .common_blank_out(blank), .polarity_out(polarity),
        .bias_discharge_out(discharge), .top_bias_level_out(top),
        .contrast_adjuster_active_out(ca_act),
        .bias_generator_active_out(bg_act), .booster_active_out(boost),
        .bias_divider_out(divider), .bias_level3_open_out(lvl3),
        .segment_map_reverse_out(seg_rev));

    // 100 MHz core clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        i_lcsc_host_model.xfer(1'b1, a, d, r);
        repeat (4) @(posedge clk_in);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        i_lcsc_host_model.xfer(1'b0, a, 32'h00000000, r);
    endtask

    task automatic conclude();
        bad_count += i_lcsc_host_model.timeouts;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Polls the cleared flag until the clear filter lets go
    task automatic wait_cleared();
        logic [31:0] r;
        int k;
        k = 0;
        do begin
            rd(`LCSC_ADDR_STATUS, r);
            k++;
        end while (r[`LCSC_STS_CLEARED] !== 1'b0 && k < 20);
        chk("cleared flag", 1'b0, r[`LCSC_STS_CLEARED]);
    endtask

    // Watches two frames: pulse order, coverage, blanking, polarity
    task automatic scan(input int n, input bit rev, input bit inv);
        logic [15:0] seen, prev, eb;
        logic pp;
        bit w;
        int i, nx, bad;
        seen = 16'h0000;
        eb = 16'h0000;
        bad = 0;
        for (i = 0; i < 16; i++)
            eb[i] = rev ? (i < 16 - n) : (i >= n);
        repeat (80) @(posedge clk_in);
        #1;
        prev = commons;
        pp = polarity;
        repeat (n * 2 * RC) begin
            @(posedge clk_in);
            #1;
            seen |= commons;
            if (commons !== prev) begin
                for (i = 0; i < 16; i++)
                    if (prev[i]) nx = i;
                nx = rev ? (nx == 16 - n ? 15 : nx - 1)
                         : (nx == n - 1 ? 0 : nx + 1);
                if (commons !== (16'h0001 << nx)) bad++;
                // Line inversion keeps its level across an even frame wrap
                w = nx == (rev ? 15 : 0);
                if ((polarity !== pp) !== (inv ? w : (!w || n % 2 == 1)))
                    bad++;
            end else if (polarity !== pp) bad++;
            prev = commons;
            pp = polarity;
        end
        chk("blank mask", eb, blank);
        chk("scanned commons", {16'h0000, ~eb}, seen);
        chk("scan order and polarity", 0, bad);
    endtask

    // Main sequence
    initial begin
        logic [31:0] r;
        int d;
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        wait_cleared();
        rd(`LCSC_ADDR_CONFIG, r);
        chk("config reset", 32'h00000000, r);
        rd(`LCSC_ADDR_CONTRAST, r);
        chk("contrast reset", 32'h00000000, r);
        rd(8'h10, r);
        chk("unmapped read", 32'h00000000, r);
        wr(`LCSC_ADDR_CONFIG, 32'h00000000);
        for (d = 0; d < 32; d++) begin
            wr(`LCSC_ADDR_CONFIG, (d & 15) | (d & 16) << 2 | (d & 2) << 4);
            scan(d[3] ? 16 : (d & 7) + 8, d[4], d[1]);
        end
        wr(`LCSC_ADDR_CONTRAST, 32'h0000002A);
        wr(`LCSC_ADDR_CONFIG, 32'h00000300);
        chk("top level", 6'h2A, top);
        chk("quarter divider", 3'h4, divider);
        chk("level3 open", 1'b1, lvl3);
        wr(`LCSC_ADDR_CONFIG, 32'h00000210);
        chk("fifth divider", 3'h5, divider);
        chk("adjuster stopped", 2'b01, {ca_act, bg_act});
        wr(`LCSC_ADDR_CONFIG, 32'h00000690);
        chk("booster and segment", 2'b11, {boost, seg_rev});
        wr(`LCSC_ADDR_CONTROL, 32'h00000001);
        chk("power save discharge", 1'b1, discharge);
        chk("booster in power save", 1'b0, boost);
        chk("discharge levels", 4'h0, {divider, bg_act});
        wr(`LCSC_ADDR_CONFIG, 32'h00000000);
        chk("idle power save", 1'b0, discharge);
        wr(`LCSC_ADDR_CONTROL, 32'h00000000);
        wr(`LCSC_ADDR_CONFIG, 32'h00000100);
        @(posedge clk_in);
        clear_n <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("clear discharge", 1'b1, discharge);
        clear_n <= 1'b1;
        wait_cleared();
        rd(`LCSC_ADDR_CONFIG, r);
        chk("config after clear", 32'h00000000, r);
        conclude();
    end
endmodule // lcsc_scan_config_tb_top
`default_nettype wire
